/* tb/kpso_keypad_model.sv */
// keypad matrix model: scan step timing and one pressed key
// assumes one clock; a press is reported once per hold of press_in
`default_nettype none
module kpso_keypad_model (
    input  wire logic       clock_in,
    input  wire logic       run_in,
    input  wire logic [7:0] gap_in,
    input  wire logic [4:0] column_drive_in,
    input  wire logic [2:0] row_limit_in,
    input  wire logic       press_in,
    input  wire logic [2:0] press_col_in,
    output logic            step_out,
    output logic            key_press_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count;
    logic       armed;
    wire        hit = press_in && armed && column_drive_in[press_col_in] && (row_limit_in != 3'h0);
    // =====================================================================
    // step strobe every gap_in+1 cycles; gap_in sets prompt or slow scanning
    always_ff @(posedge clock_in) begin
        if (!run_in) begin
            count    <= 8'h00;
            step_out <= 1'b0;
        end else begin
            step_out <= (count == gap_in);
            count    <= (count == gap_in) ? 8'h00 : count + 8'h01;
        end
    end
    // =====================================================================
    // a key closes only while its column is driven; one pulse per press
    always_ff @(posedge clock_in) begin
        key_press_out <= hit;
        if (!press_in) begin
            armed <= 1'b1;
        end else if (hit) begin
            armed <= 1'b0;
        end
    end
endmodule // kpso_keypad_model
`default_nettype wire

/* tb/testbench.sv */
// bench for the keypad scan order block: apb register tasks and scenarios
// assumes the design package, design files and keypad model compile first
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] A_SCAN = {kpso_pkg::IDX_SCAN_CONTROL, 2'b00};
    localparam logic [17:0] A_DIM  = {kpso_pkg::IDX_DIMENSIONS, 2'b00};
    localparam logic [17:0] A_LOW  = {kpso_pkg::IDX_ORDER_LOW, 2'b00};
    localparam logic [17:0] A_HIGH = {kpso_pkg::IDX_ORDER_HIGH, 2'b00};
    localparam logic [17:0] A_IRQ  = {kpso_pkg::IDX_IRQ_CONTROL, 2'b00};
    logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    logic        run = 1'b0, press = 1'b0;
    logic [7:0]  gap = 8'h06;
    logic [2:0]  pcol = 3'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, key_press, step, irq, pd_select, errv;
    logic [4:0]  drive;
    logic [2:0]  rows;
    logic [31:0] rdv;
    logic [2:0]  ord [5];
    int          fail_count = 0;
    int          n_checks = 0;
    always #4 clock = ~clock;
    kpso_top dut (.clock_in(clock), .resetn_in(resetn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .key_press_in(key_press), .step_in(step), .column_drive_out(drive),
        .row_limit_out(rows), .keypad_irq_out(irq), .powerdown_mux_select_out(pd_select));
    kpso_keypad_model pad (.clock_in(clock), .run_in(run), .gap_in(gap),
        .column_drive_in(drive), .row_limit_in(rows), .press_in(press),
        .press_col_in(pcol), .step_out(step), .key_press_out(key_press));
    // =====================================================================
    // report and compare
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic wait_high(ref logic s, input int limit);
        int n;
        n = 0;
        while (s !== 1'b1 && n < limit) begin
            @(posedge clock);
            n++;
        end
        if (n >= limit) begin
            fail_count++;
            finish_test();
        end
    endtask
    // =====================================================================
    // apb master: setup, access held until pready, release after that edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= 4'hF;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        wait_high(pready, 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // second idle edge: outputs launched after the write are settled on return
        repeat (2) @(posedge clock);
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check("read data", rdv, {24'h000000, exp});
    endtask
    task automatic load_order(input logic [2:0] s0, s1, s2, s3, s4);
        ord = '{s0, s1, s2, s3, s4};
        wr(A_LOW, {s2[1:0], s1, s0});
        wr(A_HIGH, {1'b0, s4, s3, s2[2]});
    endtask
    function automatic logic [31:0] onehot(input logic [2:0] s);
        return (s < 3'h5) ? (32'h00000001 << s) : 32'h00000000;
    endfunction
    // column after each model step follows the slot list, wrapping at ncols
    task automatic step_check(input int nsteps, input int ncols);
        for (int i = 1; i <= nsteps; i++) begin
            wait_high(step, 40);
            repeat (3) @(posedge clock);
            check("column drive", {27'h0, drive}, onehot(ord[i % ncols]));
        end
    endtask
    // =====================================================================
    // scenarios
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("idle outputs", {drive, rows, irq, pd_select}, 32'h0);
        rd(A_SCAN, 8'h00);
        rd(A_DIM, 8'h00);
        rd(A_LOW, 8'h00);
        rd(A_HIGH, 8'h00);
        rd(A_IRQ, 8'h00);
        rd(18'h00010, 8'h00);
        check("unmapped error", {31'h0, errv}, 32'h1);
        wr(A_DIM, 8'hFF);
        rd(A_DIM, 8'h3F);
        wr(A_LOW, 8'hFF);
        rd(A_LOW, 8'hFF);
        wr(A_HIGH, 8'hFF);
        rd(A_HIGH, 8'h7F);
        wr(A_SCAN, 8'h04);
        check("row limit", {29'h0, rows}, 32'h6);
        load_order(3'h3, 3'h1, 3'h4, 3'h0, 3'h2);
        wr(A_DIM, 8'h1F);
        check("row limit", {29'h0, rows}, 32'h3);
        check("first column", {27'h0, drive}, onehot(3'h3));
        run <= 1'b1;
        step_check(11, 5);
        run <= 1'b0;
        gap <= 8'h0C;
        // restart the walk at the first slot
        wr(A_SCAN, 8'h00);
        wr(A_SCAN, 8'h04);
        load_order(3'h5, 3'h2, 3'h0, 3'h1, 3'h1);
        wr(A_DIM, 8'h1A);
        run <= 1'b1;
        step_check(5, 2);
        run <= 1'b0;
        wr(A_SCAN, 8'h00);
        repeat (3) @(posedge clock);
        check("scan off", {drive, rows}, 32'h0);
        load_order(3'h0, 3'h1, 3'h2, 3'h3, 3'h4);
        wr(A_DIM, 8'h2D);
        wr(A_SCAN, 8'h04);
        wr(A_IRQ, 8'h80);
        check("powerdown select", {31'h0, pd_select}, 32'h1);
        pcol <= 3'h2;
        press <= 1'b1;
        run <= 1'b1;
        wait_high(key_press, 200);
        repeat (3) @(posedge clock);
        press <= 1'b0;
        check("masked irq", {31'h0, irq}, 32'h0);
        rd(A_IRQ, 8'h81);
        rd(A_IRQ, 8'h80);
        rd(A_SCAN, 8'h06);
        rd(A_SCAN, 8'h04);
        wr(A_IRQ, 8'h02);
        pcol <= 3'h4;
        press <= 1'b1;
        wait_high(irq, 200);
        press <= 1'b0;
        load_order(3'h4, 3'h3, 3'h2, 3'h1, 3'h0);
        rd(A_IRQ, 8'h03);
        repeat (2) @(posedge clock);
        check("irq after read", {31'h0, irq}, 32'h0);
        run <= 1'b0;
        finish_test();
    end
endmodule // testbench
`default_nettype wire

/* verilog/kpso_clamp.sv */
// count clamp: limits a programmed count to its maximum
// assumes combinational use only
`default_nettype none
module kpso_clamp (
    input  wire logic [2:0] value_in,
    input  wire logic [2:0] limit_in,
    output logic      [2:0] clamped_out
);
    // =====================================================================
    // clamp
    assign clamped_out = (value_in > limit_in) ? limit_in : value_in;
endmodule // kpso_clamp
`default_nettype wire

/* verilog/kpso_pkg.sv */
// keypad scan order configuration: shared constants and carrier types
// assumes one system clock and a synchronous active-low reset
`default_nettype none
package kpso_pkg;
    // =====================================================================
    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] IDX_DIMENSIONS   = 16'h00D5;
    localparam logic [15:0] IDX_ORDER_LOW    = 16'h00D6;
    localparam logic [15:0] IDX_ORDER_HIGH   = 16'h00D7;
    localparam logic [15:0] IDX_IRQ_CONTROL  = 16'hFF94;
    localparam logic [15:0] IDX_SCAN_CONTROL = 16'h00D4;
    localparam int          ADDR_W           = 18;
    // =====================================================================
    // field positions
    localparam int ROW_LSB      = 3;
    localparam int COL_LSB      = 0;
    localparam int SLOT_W       = 3;
    localparam int NUM_SLOTS    = 5;
    localparam int IRQ_EN_BIT   = 1;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int POWERDOWN_MUX_BIT = 7;
    localparam int SCAN_EN_BIT  = 2;
    localparam logic [2:0] MAX_ROWS = 3'h6;
    localparam logic [2:0] MAX_COLS = 3'h5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] HIGH_MASK  = 8'h7F;
    localparam logic [7:0] DIM_MASK   = 8'h3F;
    // =====================================================================
    // settings carried from the register file to the scanner
    typedef struct packed {
        logic        scan_en;
        logic [2:0]  row_count;
        logic [2:0]  column_count;
        logic [14:0] order;
    } kpso_cfg_t;
endpackage
`default_nettype wire

/* verilog/kpso_stepper.sv */
// column stepper: walks the order slots and drives one column
// assumes the step strobe comes from the scan timing outside
`default_nettype none
module kpso_stepper (
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    input  wire kpso_pkg::kpso_cfg_t  cfg_in,
    input  wire logic [2:0]           col_limit_in,
    input  wire logic                 step_in,
    output logic      [4:0]           column_drive_out,
    output logic      [2:0]           slot_out
);
    // =====================================================================
    // slot walk
    logic [2:0] slot;
    logic [2:0] next_slot;
    logic [2:0] slot_value;
    logic       last_slot;

    function automatic logic [2:0] pick_slot(input logic [14:0] ord, input logic [2:0] s);
        pick_slot = ord[s*kpso_pkg::SLOT_W +: kpso_pkg::SLOT_W];
    endfunction

    assign last_slot  = (slot + 3'h1 >= col_limit_in);
    assign next_slot  = (!cfg_in.scan_en || last_slot) ? 3'h0 : slot + 3'h1;
    assign slot_value = pick_slot(cfg_in.order, slot);

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            slot             <= 3'h0;
            column_drive_out <= 5'h00;
        end else begin
            // a count shrunk below the current slot restarts the walk at once
            if (step_in || !cfg_in.scan_en || slot >= col_limit_in) begin
                slot <= next_slot;
            end
            // no drive when scanning is off, or slot value beyond column four
            if (cfg_in.scan_en && slot < col_limit_in && slot_value < 3'h5) begin
                column_drive_out <= 5'h01 << slot_value;
            end else begin
                column_drive_out <= 5'h00;
            end
        end
    end
    assign slot_out = slot;

    // one cycle of grace after the column count changes
    a_slot_bounded: assert property (@(posedge clock_in) disable iff (!resetn_in)
        cfg_in.scan_en && col_limit_in != 3'h0 && $stable(col_limit_in)
        |-> slot < col_limit_in)
        else $error("slot beyond column count");
endmodule // kpso_stepper
`default_nettype wire

/* verilog/kpso_top.sv */
// keypad scan order configuration block with APB register slave
// assumes key detect arrives as a one-cycle pulse from debounce logic
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module kpso_top (
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [17:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        key_press_in,
    input  wire logic        step_in,
    output logic      [4:0]  column_drive_out,
    output logic      [2:0]  row_limit_out,
    output logic             keypad_irq_out,
    output logic             powerdown_mux_select_out
);
    // =====================================================================
    // register state
    logic [7:0] keypad_dimensions;
    logic [7:0] column_order_low;
    logic [7:0] column_order_high;
    logic       keypad_irq_enable;
    logic       keypad_irq_flag;
    logic       powerdown_mux_select;
    logic       auto_scan_enable;
    logic       key_found_flag;

    // =====================================================================
    // bus decode
    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    wire access_cyc  = psel_in && penable_in;
    wire wr_cyc      = access_cyc && pwrite_in && pstrb_in[0];
    wire rd_cyc      = access_cyc && !pwrite_in;
    wire sel_dim     = hit(paddr_in, kpso_pkg::IDX_DIMENSIONS);
    wire sel_low     = hit(paddr_in, kpso_pkg::IDX_ORDER_LOW);
    wire sel_high    = hit(paddr_in, kpso_pkg::IDX_ORDER_HIGH);
    wire sel_irq     = hit(paddr_in, kpso_pkg::IDX_IRQ_CONTROL);
    wire sel_scan    = hit(paddr_in, kpso_pkg::IDX_SCAN_CONTROL);
    wire mapped      = sel_dim | sel_low | sel_high | sel_irq | sel_scan;
    wire [7:0] wbyte = pwdata_in[7:0];

    // read of irq control clears its flag; a same-cycle detect still wins
    wire irq_read    = rd_cyc && sel_irq;
    wire scan_read   = rd_cyc && sel_scan;
    wire key_event   = key_press_in && auto_scan_enable;

    wire [7:0] irq_byte  = {powerdown_mux_select, 5'h00, keypad_irq_enable, keypad_irq_flag};
    wire [7:0] scan_byte = {5'h00, auto_scan_enable, key_found_flag, 1'b0};
    wire [7:0] rd_byte   = sel_dim  ? keypad_dimensions :
                           sel_low  ? column_order_low  :
                           sel_high ? column_order_high :
                           sel_irq  ? irq_byte          :
                           sel_scan ? scan_byte         : kpso_pkg::RESET_BYTE;

    // =====================================================================
    // configuration to the scanner
    kpso_pkg::kpso_cfg_t cfg;
    logic [2:0]          col_limit;
    logic [2:0]          row_limit;

    assign cfg.scan_en      = auto_scan_enable;
    assign cfg.row_count    = keypad_dimensions[kpso_pkg::ROW_LSB +: 3];
    assign cfg.column_count = keypad_dimensions[kpso_pkg::COL_LSB +: 3];
    // order bits 7:0 from low, 14:8 from high
    assign cfg.order        = {column_order_high[6:0], column_order_low};

    kpso_clamp u_row_clamp (
        .value_in    (cfg.row_count),
        .limit_in    (kpso_pkg::MAX_ROWS),
        .clamped_out (row_limit)
    );
    kpso_clamp u_col_clamp (
        .value_in    (cfg.column_count),
        .limit_in    (kpso_pkg::MAX_COLS),
        .clamped_out (col_limit)
    );

    kpso_stepper u_stepper (
        .clock_in         (clock_in),
        .resetn_in        (resetn_in),
        .cfg_in           (cfg),
        .col_limit_in     (col_limit),
        .step_in          (step_in),
        .column_drive_out (column_drive_out),
        .slot_out         ()
    );

    // =====================================================================
    // register writes
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            keypad_dimensions    <= kpso_pkg::RESET_BYTE;
            column_order_low     <= kpso_pkg::RESET_BYTE;
            column_order_high    <= kpso_pkg::RESET_BYTE;
            keypad_irq_enable    <= 1'b0;
            powerdown_mux_select <= 1'b0;
            auto_scan_enable     <= 1'b0;
        end else if (wr_cyc) begin
            if (sel_dim)  keypad_dimensions <= wbyte & kpso_pkg::DIM_MASK;
            if (sel_low)  column_order_low  <= wbyte;
            if (sel_high) column_order_high <= wbyte & kpso_pkg::HIGH_MASK;
            if (sel_irq) begin
                keypad_irq_enable    <= wbyte[kpso_pkg::IRQ_EN_BIT];
                powerdown_mux_select <= wbyte[kpso_pkg::POWERDOWN_MUX_BIT];
            end
            if (sel_scan) auto_scan_enable <= wbyte[kpso_pkg::SCAN_EN_BIT];
        end
    end

    // =====================================================================
    // sticky flags: set beats clear-on-read
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            keypad_irq_flag <= 1'b0;
            key_found_flag  <= 1'b0;
        end else begin
            keypad_irq_flag <= key_event | (keypad_irq_flag & ~irq_read);
            key_found_flag  <= key_event | (key_found_flag & ~scan_read);
        end
    end

    // =====================================================================
    // outputs, all registered
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            prdata_out               <= 32'h00000000;
            pready_out               <= 1'b0;
            pslverr_out              <= 1'b0;
            keypad_irq_out           <= 1'b0;
            row_limit_out            <= 3'h0;
            powerdown_mux_select_out <= 1'b0;
        end else begin
            // ready is raised in setup so the access phase completes at once
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
            prdata_out  <= (psel_in && !penable_in) ? {24'h000000, rd_byte} : 32'h00000000;
            keypad_irq_out           <= keypad_irq_flag & keypad_irq_enable;
            row_limit_out            <= auto_scan_enable ? row_limit : 3'h0;
            powerdown_mux_select_out <= powerdown_mux_select;
        end
    end

    // =====================================================================
    // checks
    a_irq_gate: assert property (@(posedge clock_in) disable iff (!resetn_in)
        keypad_irq_out |-> $past(keypad_irq_enable))
        else $error("interrupt passed while disabled");
    a_flag_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
        key_event |=> keypad_irq_flag)
        else $error("key detect did not set flag");
    a_flag_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
        irq_read && !key_event |=> !keypad_irq_flag)
        else $error("flag not cleared by read");
    a_found_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
        key_event |=> key_found_flag)
        else $error("key press did not set found flag");
    a_found_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
        scan_read && !key_event |=> !key_found_flag)
        else $error("key found flag not cleared");
    a_no_scan_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !auto_scan_enable [*2] |-> column_drive_out == 5'h00)
        else $error("column driven with scanning off");
    a_row_scan_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !auto_scan_enable |=> row_limit_out == 3'h0)
        else $error("row limit shown with scanning off");
    a_one_column: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $onehot0(column_drive_out))
        else $error("more than one column driven");
    a_col_clamp: assert property (@(posedge clock_in) disable iff (!resetn_in)
        col_limit <= kpso_pkg::MAX_COLS && row_limit <= kpso_pkg::MAX_ROWS)
        else $error("count above maximum");
    a_high_unused: assert property (@(posedge clock_in) disable iff (!resetn_in)
        column_order_high[7] == 1'b0)
        else $error("unused order bit set");
    a_ready_fast: assert property (@(posedge clock_in) disable iff (!resetn_in)
        psel_in && !penable_in |=> pready_out)
        else $error("access not answered in one cycle");
    a_ready_access: assert property (@(posedge clock_in) disable iff (!resetn_in)
        psel_in && penable_in |-> pready_out)
        else $error("access phase without ready");
    a_err_unmapped: assert property (@(posedge clock_in) disable iff (!resetn_in)
        psel_in && !penable_in && !mapped |=> pslverr_out)
        else $error("unmapped access not flagged");
endmodule // kpso_top
`default_nettype wire
